// File: logic/iso_pkg.sv
package iso_pkg;

    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned SLOT_TIME_NS     = 100;
    localparam int unsigned SLOT_CYC         = SLOT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned MAX_ISO_LAT_NS   = 2000;
    localparam int unsigned MAX_ISO_LAT_CYC  = MAX_ISO_LAT_NS / CLK_PERIOD_NS;

    localparam int unsigned NUM_SLOTS        = 8;
    localparam int unsigned SLOT_IDX_W       = 3;
    localparam int unsigned FIFO_DEPTH       = 16;
    localparam int unsigned LEN_W            = 10;
    localparam int unsigned DATA_W           = 32;
    localparam int unsigned TC_W             = 3;
    localparam int unsigned NUM_TC           = 8;
    localparam int unsigned CAP_W            = 7;
    localparam int unsigned AGE_W            = 12;
    localparam int unsigned SCNT_W           = 8;

    // Raw slot capacity, less slots lost to partial-write read-modify-write
    localparam logic [CAP_W-1:0] RAW_TIME_SLOTS     = 7'h08;
    localparam logic [CAP_W-1:0] PARTIAL_WR_SLOTS   = 7'h02;
    localparam logic [CAP_W-1:0] CAP_TIME_SLOTS     =
        RAW_TIME_SLOTS - PARTIAL_WR_SLOTS;
    // Payload size code n means 32 << n dwords (128 << n bytes)
    localparam logic [LEN_W-1:0] MPS_BASE_DW        = 10'h020;
    localparam logic [2:0]       MPS_CODE_MAX       = 3'h5;

    typedef struct packed {
        logic              cpl;
        logic              rd;
        logic [TC_W-1:0]   tc;
        logic              ns;
        logic [LEN_W-1:0]  len;
        logic [DATA_W-1:0] data;
    } req_t;

    localparam int unsigned REQ_W = $bits(req_t);

endpackage

// File: logic/iso_link_if.sv
`timescale 1ns/10ps
interface iso_link_if;
    import iso_pkg::*;

    logic                 req_valid;
    logic                 req_ready;
    req_t                 req;
    logic                 rsp_valid;
    logic                 rsp_reject;
    logic [CAP_W-1:0]     cap_slots;
    logic                 cap_rej_snoop;

    modport requester (
        output req_valid,
        input  req_ready,
        output req,
        input  rsp_valid,
        input  rsp_reject,
        input  cap_slots,
        input  cap_rej_snoop
    );

    modport completer (
        input  req_valid,
        output req_ready,
        input  req,
        output rsp_valid,
        output rsp_reject,
        output cap_slots,
        output cap_rej_snoop
    );

endinterface

// File: logic/iso_fifo.sv
`timescale 1ns/10ps
module iso_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    wr_d;
    logic [AW-1:0]    rd_q;
    logic [AW-1:0]    rd_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage has no reset; contents are qualified by the count
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

endmodule

// File: logic/iso_completer.sv
`timescale 1ns/10ps
module iso_completer
    import iso_pkg::*;
(
    input  wire logic                  clk_sys_i,
    input  wire logic                  nrst_i,
    iso_link_if.completer              link,
    input  wire logic [NUM_TC-1:0]     cfg_tc_vc_map_i,
    input  wire logic [NUM_SLOTS-1:0]  cfg_slot_map_i,
    input  wire logic                  cfg_rej_snoop_i,
    input  wire logic                  late_clr_i,
    output logic                       svc_valid_o,
    output logic                       svc_cpl_o,
    output logic                       svc_iso_o,
    output logic                       svc_rd_o,
    output logic      [TC_W-1:0]       svc_tc_o,
    output logic      [LEN_W-1:0]      svc_len_o,
    output logic      [DATA_W-1:0]     svc_data_o,
    output logic                       late_o,
    output logic      [SLOT_IDX_W-1:0] slot_idx_o
);
    logic             head_valid;
    logic [REQ_W-1:0] head_bits;
    req_t             head;
    logic             grant;
    logic             head_iso;
    logic             reject;

    // Depth absorbs a uniform isochronous burst without holding credit
    iso_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .in_valid_i  (link.req_valid),
        .in_ready_o  (link.req_ready),
        .in_data_i   (link.req),
        .out_valid_o (head_valid),
        .out_ready_i (grant),
        .out_data_o  (head_bits)
    );

    assign head = req_t'(head_bits);

    // Slot timer
    logic [SCNT_W-1:0]     scnt_q;
    logic [SCNT_W-1:0]     scnt_d;
    logic [SLOT_IDX_W-1:0] sidx_q;
    logic [SLOT_IDX_W-1:0] sidx_d;
    logic                  token_q;
    logic                  token_d;
    logic                  slot_end;

    assign slot_end = (scnt_q == SCNT_W'(SLOT_CYC - 1));

    always_comb begin
        // One TC-to-VC map stands for every function of the link
        head_iso = cfg_tc_vc_map_i[head.tc];
        grant    = 1'b0;
        if (head_valid) begin
            if (head.cpl) begin
                grant = 1'b1;
            end else if (head_iso) begin
                grant = token_q;
            end else begin
                grant = ~cfg_slot_map_i[sidx_q];
            end
        end
        scnt_d  = slot_end ? '0 : scnt_q + SCNT_W'(1);
        sidx_d  = slot_end ? sidx_q + SLOT_IDX_W'(1) : sidx_q;
        token_d = token_q;
        if (grant && head_iso && !head.cpl) begin
            token_d = 1'b0;
        end
        if (slot_end) begin
            // One isochronous request per owned slot
            token_d = cfg_slot_map_i[sidx_d];
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            scnt_q  <= '0;
            sidx_q  <= '0;
            token_q <= 1'b0;
        end else begin
            scnt_q  <= scnt_d;
            sidx_q  <= sidx_d;
            token_q <= token_d;
        end
    end

    // Head age and lateness
    logic [AGE_W-1:0] age_q;
    logic [AGE_W-1:0] age_d;
    logic             late_q;
    logic             late_d;

    always_comb begin
        age_d = '0;
        if (head_valid && !grant && age_q != '1) begin
            age_d = age_q + AGE_W'(1);
        end
        late_d = late_q & ~late_clr_i;
        // Set wins over a clear in the same cycle
        if (grant && head_iso && !head.cpl
            && age_q > AGE_W'(MAX_ISO_LAT_CYC)) begin
            late_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            age_q  <= '0;
            late_q <= 1'b0;
        end else begin
            age_q  <= age_d;
            late_q <= late_d;
        end
    end

    // Service and response outputs
    logic             rsp_v_q;
    logic             rsp_v_d;
    logic             rsp_rej_q;
    logic             rsp_rej_d;
    logic             sv_q;
    logic             sv_d;
    logic             siso_q;
    logic             siso_d;
    req_t             sreq_q;
    req_t             sreq_d;

    assign reject = head_iso & ~head.cpl & cfg_rej_snoop_i & ~head.ns;

    always_comb begin
        rsp_v_d   = grant & ~head.cpl;
        rsp_rej_d = grant & reject;
        sv_d      = grant & ~reject;
        siso_d    = grant ? head_iso : siso_q;
        sreq_d    = grant ? head : sreq_q;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rsp_v_q   <= 1'b0;
            rsp_rej_q <= 1'b0;
            sv_q      <= 1'b0;
            siso_q    <= 1'b0;
            sreq_q    <= '0;
        end else begin
            rsp_v_q   <= rsp_v_d;
            rsp_rej_q <= rsp_rej_d;
            sv_q      <= sv_d;
            siso_q    <= siso_d;
            sreq_q    <= sreq_d;
        end
    end

    // Capability advertisement: slot count fixed, snoop rejection flag follows config one cycle later
    logic cap_rs_q;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cap_rs_q <= 1'b0;
        end else begin
            cap_rs_q <= cfg_rej_snoop_i;
        end
    end

    assign link.cap_slots     = CAP_TIME_SLOTS;
    assign link.cap_rej_snoop = cap_rs_q;
    assign link.rsp_valid     = rsp_v_q;
    assign link.rsp_reject    = rsp_rej_q;

    assign svc_valid_o = sv_q;
    assign svc_cpl_o   = sreq_q.cpl;
    assign svc_iso_o   = siso_q;
    assign svc_rd_o    = sreq_q.rd;
    assign svc_tc_o    = sreq_q.tc;
    assign svc_len_o   = sreq_q.len;
    assign svc_data_o  = sreq_q.data;
    assign late_o      = late_q;
    assign slot_idx_o  = sidx_q;

endmodule

// File: logic/iso_requester.sv
`timescale 1ns/10ps
module iso_requester
    import iso_pkg::*;
(
    input  wire logic                 clk_sys_i,
    input  wire logic                 nrst_i,
    iso_link_if.requester             link,
    input  wire logic                 usr_valid_i,
    output logic                      usr_ready_o,
    input  wire logic                 usr_cpl_i,
    input  wire logic                 usr_rd_i,
    input  wire logic [TC_W-1:0]      usr_tc_i,
    input  wire logic [LEN_W-1:0]     usr_len_i,
    input  wire logic [DATA_W-1:0]    usr_data_i,
    input  wire logic [NUM_TC-1:0]    cfg_tc_vc_map_i,
    input  wire logic [2:0]           cfg_mps_i,
    input  wire logic [2:0]           cfg_mrrs_i,
    input  wire logic [CAP_W-1:0]     cfg_slots_i,
    output logic                      cfg_err_o,
    output logic                      cfg_warn_o,
    output logic                      rej_o
);
    logic [LEN_W:0]   mps_dw;
    logic             iso;
    logic             accept;
    req_t             req_q;
    req_t             req_d;
    logic             vld_q;
    logic             vld_d;
    logic             rdy_q;
    logic             rdy_d;
    logic             err_q;
    logic             err_d;
    logic             warn_q;
    logic             warn_d;
    logic             rej_q;
    logic             rej_d;

    assign accept = usr_valid_i & rdy_q;

    always_comb begin
        // Extra bit keeps the largest size from wrapping to zero
        mps_dw = (LEN_W+1)'(MPS_BASE_DW) << ((cfg_mps_i > MPS_CODE_MAX)
                                 ? MPS_CODE_MAX : cfg_mps_i);
        iso    = cfg_tc_vc_map_i[usr_tc_i];
        req_d  = req_q;
        if (accept) begin
            req_d.cpl  = usr_cpl_i;
            req_d.rd   = usr_rd_i;
            req_d.tc   = usr_tc_i;
            req_d.data = usr_data_i;
            req_d.len  = usr_len_i;
            if (usr_rd_i && !usr_cpl_i && {1'b0, usr_len_i} > mps_dw) begin
                req_d.len = mps_dw[LEN_W-1:0];
            end
            // Same no-snoop value on every isochronous request that is not a completion; completions carry ns clear
            req_d.ns = iso & link.cap_rej_snoop & ~usr_cpl_i;
        end
        vld_d = (vld_q & ~link.req_ready) | accept;
        // Single holding stage; trades throughput for a flopped ready
        rdy_d = ~vld_d;
        err_d = (cfg_tc_vc_map_i == '0)
              | (cfg_slots_i > link.cap_slots)
              | (cfg_slots_i >= CAP_W'(NUM_SLOTS))
              | (cfg_mrrs_i > cfg_mps_i);
        warn_d = (cfg_tc_vc_map_i == '1);
        rej_d  = link.rsp_valid & link.rsp_reject;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            req_q  <= '0;
            vld_q  <= 1'b0;
            rdy_q  <= 1'b0;
            err_q  <= 1'b0;
            warn_q <= 1'b0;
            rej_q  <= 1'b0;
        end else begin
            req_q  <= req_d;
            vld_q  <= vld_d;
            rdy_q  <= rdy_d;
            err_q  <= err_d;
            warn_q <= warn_d;
            rej_q  <= rej_d;
        end
    end

    assign link.req_valid = vld_q;
    assign link.req       = req_q;
    assign usr_ready_o    = rdy_q;
    assign cfg_err_o      = err_q;
    assign cfg_warn_o     = warn_q;
    assign rej_o          = rej_q;

endmodule

// File: tb/iso_link_props.sv
`timescale 1ns/10ps
module iso_link_props
    import iso_pkg::*;
(
    input  wire logic             clk_sys_i,
    input  wire logic             nrst_i,
    input  wire logic             req_valid,
    input  wire logic             req_ready,
    input  wire req_t             req,
    input  wire logic             rsp_valid,
    input  wire logic             rsp_reject,
    input  wire logic [CAP_W-1:0] cap_slots,
    input  wire logic             cap_rej_snoop
);
    // Takes less responses bound the fifo fill from above
    logic [4:0] taken_q;
    logic [4:0] taken_d;
    logic [4:0] open_q;
    logic [4:0] open_d;
    logic       take;

    assign take = req_valid && req_ready;

    always_comb begin
        taken_d = taken_q;
        open_d  = open_q;
        if (take) begin
            taken_d = taken_d + 5'h01;
        end
        if (rsp_valid) begin
            taken_d = taken_d - 5'h01;
        end
        if (take && !req.cpl) begin
            open_d = open_d + 5'h01;
        end
        if (rsp_valid) begin
            open_d = open_d - 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            taken_q <= 5'h00;
            open_q  <= 5'h00;
        end else begin
            taken_q <= taken_d;
            open_q  <= open_d;
        end
    end

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    property p_cap_slots; cap_slots == 7'h06; endproperty
    a_cap_slots: assert property (p_cap_slots)
        else $error("slot capacity wrong");
    property p_req_hold;
        req_valid && !req_ready |=> req_valid && $stable(req);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request changed while waiting");
    property p_ns_flag; req_valid && req.ns |-> cap_rej_snoop && !req.cpl;
    endproperty
    a_ns_flag: assert property (p_ns_flag)
        else $error("no-snoop set without cause");
    property p_rej_flag; rsp_reject |-> rsp_valid && cap_rej_snoop;
    endproperty
    a_rej_flag: assert property (p_rej_flag)
        else $error("reject without snoop rejection");
    property p_ready_free; taken_q < 5'h10 |-> req_ready; endproperty
    a_ready_free: assert property (p_ready_free)
        else $error("backpressure before fifo full");
    property p_rsp_source; rsp_valid |-> open_q != 5'h00; endproperty
    a_rsp_source: assert property (p_rsp_source)
        else $error("response with no open request");
    property p_min_lat; take && open_q == 5'h00 |=> !rsp_valid; endproperty
    a_min_lat: assert property (p_min_lat)
        else $error("response too early");
    property p_idle_reset; $rose(nrst_i) |-> !req_valid ##1 !rsp_valid;
    endproperty
    a_idle_reset: assert property (p_idle_reset)
        else $error("activity right after reset");
endmodule

// File: tb/tb_isochronous_service_policy.sv
`timescale 1ns/10ps
module tb_isochronous_service_policy import iso_pkg::*;;
    logic                 clk_sys_i, nrst_i, late_clr, rej_snoop;
    logic                 usr_valid_i, usr_ready_o, usr_cpl_i, usr_rd_i;
    logic [TC_W-1:0]      usr_tc_i, svc_tc_o;
    logic [LEN_W-1:0]     usr_len_i, svc_len_o;
    logic [DATA_W-1:0]    usr_data_i, svc_data_o;
    logic [NUM_TC-1:0]    req_map, cpl_map;
    logic [2:0]           mps, mrrs;
    logic [CAP_W-1:0]     slots;
    logic [NUM_SLOTS-1:0] slot_map;
    logic                 cfg_err_o, cfg_warn_o, rej_o, late_o;
    logic                 svc_valid_o, svc_cpl_o, svc_iso_o, svc_rd_o;
    logic [47:0]          svc;
    logic [47:0]          exp_q[$];
    logic [47:0]          exp_item;
    logic [SLOT_IDX_W-1:0] slot_idx;
    int                   n_errors, num_checks, n_rej, i, cyc;
    // Config table: tc map, slots, read size, {error, warning}
    logic [7:0]           tmap [5] = '{8'h40, 8'h00, 8'h40, 8'h40, 8'hFF};
    logic [6:0]           tslot[5] = '{7'h06, 7'h06, 7'h07, 7'h06, 7'h06};
    logic [2:0]           tmrrs[5] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h1};
    logic [1:0]           tres [5] = '{2'h0, 2'h2, 2'h2, 2'h2, 2'h1};

    assign svc = {svc_cpl_o, svc_rd_o, svc_tc_o, svc_iso_o, svc_len_o,
                  svc_data_o};

    iso_link_if iso_link_if_inst ();
    iso_requester iso_requester_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(iso_link_if_inst),
        .usr_valid_i(usr_valid_i), .usr_ready_o(usr_ready_o),
        .usr_cpl_i(usr_cpl_i), .usr_rd_i(usr_rd_i), .usr_tc_i(usr_tc_i),
        .usr_len_i(usr_len_i), .usr_data_i(usr_data_i),
        .cfg_tc_vc_map_i(req_map), .cfg_mps_i(mps), .cfg_mrrs_i(mrrs),
        .cfg_slots_i(slots), .cfg_err_o(cfg_err_o),
        .cfg_warn_o(cfg_warn_o), .rej_o(rej_o));
    iso_completer iso_completer_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .link(iso_link_if_inst),
        .cfg_tc_vc_map_i(cpl_map), .cfg_slot_map_i(slot_map),
        .cfg_rej_snoop_i(rej_snoop), .late_clr_i(late_clr),
        .svc_valid_o(svc_valid_o), .svc_cpl_o(svc_cpl_o),
        .svc_iso_o(svc_iso_o), .svc_rd_o(svc_rd_o), .svc_tc_o(svc_tc_o),
        .svc_len_o(svc_len_o), .svc_data_o(svc_data_o),
        .late_o(late_o), .slot_idx_o(slot_idx));
    iso_link_props iso_link_props_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
        .req_valid(iso_link_if_inst.req_valid),
        .req_ready(iso_link_if_inst.req_ready),
        .req(iso_link_if_inst.req),
        .rsp_valid(iso_link_if_inst.rsp_valid),
        .rsp_reject(iso_link_if_inst.rsp_reject),
        .cap_slots(iso_link_if_inst.cap_slots),
        .cap_rej_snoop(iso_link_if_inst.cap_rej_snoop));

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk_item(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick;
        @(posedge clk_sys_i);
        #1;
    endtask

    // Model side: reads clamp to payload size, rejects never serviced
    task automatic send(input logic cpl, input logic rd,
                        input logic [TC_W-1:0] tc, input logic rej);
        logic [LEN_W-1:0] el;
        int               k;
        int               mx;
        usr_cpl_i   = cpl;
        usr_rd_i    = rd;
        usr_tc_i    = tc;
        usr_len_i   = LEN_W'($urandom);
        usr_data_i  = $urandom;
        usr_valid_i = 1'b1;
        mx = int'(MPS_BASE_DW) << mps;
        el = usr_len_i;
        if (rd && !cpl && int'(el) > mx) begin
            el = LEN_W'(mx);
        end
        for (k = 0; k < 50 && usr_ready_o !== 1'b1; k++) tick();
        if (k == 50) begin
            n_errors++;
            test_done();
        end
        tick();
        usr_valid_i = 1'b0;
        if (!rej) begin
            exp_q.push_back({cpl, rd, tc, cpl_map[tc], el, usr_data_i});
        end
        tick();
    endtask

    task automatic drain(input int lim);
        int k;
        for (k = 0; k < lim && exp_q.size() != 0; k++) tick();
        if (exp_q.size() != 0) begin
            n_errors++;
            test_done();
        end
        repeat (3) tick();
    endtask

    // Sampled mid-cycle, so flop outputs are settled
    always @(negedge clk_sys_i) begin
        if (nrst_i && svc_valid_o === 1'b1) begin
            exp_item = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
            chk_item(svc, exp_item);
        end
        if (nrst_i) begin
            chk_flag(8'(slot_idx), 8'(cyc / SLOT_CYC % NUM_SLOTS));
        end
        if (nrst_i && rej_o === 1'b1) begin
            n_rej++;
        end
    end

    // Edges since reset release drive the slot index model
    always @(posedge clk_sys_i) begin
        if (nrst_i) begin
            cyc++;
        end
    end

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        test_done();
    end

    initial begin
        {nrst_i, usr_valid_i, usr_cpl_i, usr_rd_i} = 4'h0;
        {usr_tc_i, usr_len_i, usr_data_i, late_clr, rej_snoop} = '0;
        {req_map, cpl_map, mps, mrrs} = {8'h40, 8'h40, 3'h1, 3'h1};
        {slots, slot_map} = {7'h06, 8'hFF};
        {n_errors, num_checks, n_rej, cyc} = '0;
        void'($urandom(81763));
        repeat (10) @(posedge clk_sys_i);
        #1;
        nrst_i = 1'b1;
        tick();
        chk_flag({4'h0, cfg_err_o, rej_o, late_o, svc_valid_o}, 8'h00);
        chk_flag(8'(iso_link_if_inst.cap_slots), 8'h06);
        $display("test reset done");
        send(1'b1, 1'b0, 3'h0, 1'b0);
        drain(20);
        $display("test completion bypass done");
        // Full slot map starves plain traffic until released
        for (i = 0; i < 17; i++) send(1'b0, 1'($urandom), 3'h0, 1'b0);
        chk_flag(8'(iso_link_if_inst.req_ready), 8'h00);
        slot_map = 8'h00;
        drain(200);
        $display("test fill and drain done");
        slot_map = 8'h55;
        for (i = 0; i < 4; i++) send(1'b0, 1'b0, 3'h6, 1'b0);
        drain(300);
        chk_flag(8'(late_o), 8'h00);
        $display("test latency done");
        // Isochronous head starved past the bound, largest read size
        mps = 3'h5;
        slot_map = 8'h00;
        send(1'b0, 1'b1, 3'h6, 1'b0);
        repeat (210) tick();
        slot_map = 8'h01;
        drain(120);
        chk_flag(8'(late_o), 8'h01);
        late_clr = 1'b1;
        tick();
        late_clr = 1'b0;
        chk_flag(8'(late_o), 8'h00);
        mps = 3'h1;
        $display("test late flag done");
        rej_snoop = 1'b1;
        cpl_map = 8'h60;
        repeat (3) tick();
        send(1'b0, 1'b0, 3'h5, 1'b1);
        send(1'b0, 1'b0, 3'h6, 1'b0);
        drain(300);
        chk_flag(8'(n_rej), 8'h01);
        $display("test snoop reject done");
        for (i = 0; i < 5; i++) begin
            {req_map, slots, mrrs} = {tmap[i], tslot[i], tmrrs[i]};
            repeat (2) tick();
            chk_flag(8'(cfg_err_o), 8'(tres[i][1]));
            chk_flag(8'(cfg_warn_o), 8'(tres[i][0]));
        end
        $display("test config done");
        test_done();
    end
endmodule
